// File: logic/rwc_params.svh
// Purpose: offsets, field positions, reset values of the register window block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   definitions only
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define RWC_OFF_CFG      5'h00
`define RWC_OFF_VAL      5'h04
`define RWC_OFF_ALCFG    5'h08
`define RWC_OFF_ALVAL    5'h0C
`define RWC_OFF_PAD      5'h10
`define RWC_OFF_W        5

// ==========================================================
// configuration/calibration fields
`define RWC_CFG_EN       15
`define RWC_CFG_WREN     13
`define RWC_CFG_SYNC     12
`define RWC_CFG_HALF     11
`define RWC_CFG_OE       10
`define RWC_PTR_HI       9
`define RWC_PTR_LO       8
`define RWC_CAL_HI       7
`define RWC_CAL_LO       0

// ==========================================================
// alarm configuration and pad fields
`define RWC_ALC_EN       15
`define RWC_ALC_CTL_LO   10
`define RWC_PAD_SEL      1
`define RWC_PAD_BUF      0

// ==========================================================
// window entries and reset values
`define RWC_IDX_NONE_VAL 3'h7
`define RWC_IDX_NONE_AL  3'h6
`define RWC_RST_BYTE     8'h00
`define RWC_RST_PTR      2'h0
`define RWC_RST_CAL      8'h00
`define RWC_RST_ALCTL    6'h00
`define RWC_RST_PAD      2'h0
`define RWC_BCD_MAX      8'h59
`define RWC_SYNC_STAGES  2

`endif

// File: logic/rwc_pkg.sv
// Purpose: shared types of the register window block
// Assumes: constants live in rwc_params.svh
// Notes:   none
package rwc_pkg;

  // ==========================================================
  // bus phase
  typedef enum logic [2:0]
  {
    RWC_IDLE = 3'b001,
    RWC_WAIT = 3'b010,
    RWC_DONE = 3'b100
  } rwc_phase_e;

  // ==========================================================
  // decoded register select
  typedef struct packed
  {
    logic cfg;
    logic val;
    logic alcfg;
    logic alval;
    logic pad;
  } rwc_sel_s;

  typedef logic [1:0] rwc_ptr_t;

endpackage

// File: logic/rwc_tick_sync.sv
// Purpose: brings the half-second tick pin into pclk and makes a pulse
// Assumes: tick pin is slow against pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module rwc_tick_sync
#(
  parameter int STAGES = 2
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pclk_en,
  input  wire logic tick_pin,
  output logic      tick_pulse
);

  logic [STAGES-1:0] sync_reg;
  logic              last_reg;

  initial
  begin
    if (STAGES < 2)
      $error("rwc_tick_sync: STAGES below 2");
  end

  // ==========================================================
  // synchroniser and rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_reg   <= '0;
      last_reg   <= 1'b0;
      tick_pulse <= 1'b0;
    end
    else if (pclk_en)
    begin
      sync_reg   <= {sync_reg[STAGES-2:0], tick_pin};
      last_reg   <= sync_reg[STAGES-1];
      tick_pulse <= sync_reg[STAGES-1] & ~last_reg;
    end
  end

endmodule // rwc_tick_sync

// File: logic/rwc_window_ctrl.sv
// Purpose: register windows and control of a clock/calendar, on APB
// Assumes: half_tick_pin pulses twice a second; por_n only at power-on
// Notes:   hours and higher are stored, not counted
`timescale 1ns/1ps
`include "rwc_params.svh"

module rwc_window_ctrl
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              por_n,
  input  wire logic              pclk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              half_tick_pin,
  output logic                   clock_out,
  output logic                   clock_out_oe,
  output logic                   module_running
);

  import rwc_pkg::*;

  initial
  begin
    if (ADDR_W < `RWC_OFF_W)
      $error("rwc_window_ctrl: ADDR_W too small");
  end

  // ==========================================================
  // state
  rwc_phase_e      phase_reg;
  rwc_sel_s        sel;
  logic            mapped;
  logic            done;
  logic            wr_done;
  logic            rd_done;
  logic            half_tick;
  logic            rollover;
  logic [31:0]     rdata_next;

  logic            clock_module_enable;
  logic            value_write_unlock;
  logic            clock_output_enable;
  logic            half_second_flag;
  logic            ripple_warning;
  rwc_ptr_t        value_window_pointer;
  logic [7:0]      drift_calibration;

  rwc_ptr_t        alarm_window_pointer;
  logic [5:0]      alarm_ctl_reg;
  logic [7:0]      alarm_config_repeat;
  logic [1:0]      pad_reg;
  logic            alarm_hit_reg;

  logic [7:0]      val_mem [0:7];
  logic [7:0]      al_mem [0:7];
  logic [2:0]      val_idx_hi;
  logic [2:0]      val_idx_lo;
  logic [2:0]      al_idx_hi;
  logic [2:0]      al_idx_lo;
  logic [7:0]      value_window_high;
  logic [7:0]      value_window_low;
  logic [7:0]      alarm_window_high;
  logic [7:0]      alarm_window_low;
  logic [8:0]      sec_inc;
  logic [8:0]      min_inc;

  // ==========================================================
  // decode
  always_comb
  begin
    sel       = '0;
    sel.cfg   = (paddr == ADDR_W'(`RWC_OFF_CFG));
    sel.val   = (paddr == ADDR_W'(`RWC_OFF_VAL));
    sel.alcfg = (paddr == ADDR_W'(`RWC_OFF_ALCFG));
    sel.alval = (paddr == ADDR_W'(`RWC_OFF_ALVAL));
    sel.pad   = (paddr == ADDR_W'(`RWC_OFF_PAD));
  end

  assign mapped  = |sel;
  assign done    = (phase_reg == RWC_DONE) & psel & penable;
  assign wr_done = done & pwrite & mapped;
  assign rd_done = done & ~pwrite & mapped;

  // window entry selection
  assign val_idx_hi = {value_window_pointer, 1'b1};
  assign val_idx_lo = {value_window_pointer, 1'b0};
  assign al_idx_hi  = {alarm_window_pointer, 1'b1};
  assign al_idx_lo  = {alarm_window_pointer, 1'b0};

  // reserved entries read zero
  assign value_window_high = (val_idx_hi == `RWC_IDX_NONE_VAL) ? 8'h00 : val_mem[val_idx_hi];
  assign value_window_low  = val_mem[val_idx_lo];
  assign alarm_window_high = (al_idx_hi == `RWC_IDX_NONE_VAL) ? 8'h00 : al_mem[al_idx_hi];
  assign alarm_window_low  = (al_idx_lo == `RWC_IDX_NONE_AL) ? 8'h00 : al_mem[al_idx_lo];

  // ==========================================================
  // bus phase: one wait cycle, then completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= RWC_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end
    else if (pclk_en)
    begin
      unique case (phase_reg)
        RWC_IDLE:
        begin
          if (psel & ~penable)
            phase_reg <= RWC_WAIT;
        end
        RWC_WAIT:
        begin
          if (psel & penable)
          begin
            phase_reg <= RWC_DONE;
            pready    <= 1'b1;
            pslverr   <= ~mapped;
            prdata    <= pwrite ? 32'h0000_0000 : rdata_next;
          end
        end
        RWC_DONE:
        begin
          phase_reg <= RWC_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          prdata    <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // read mux
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (sel.cfg)
      rdata_next[15:0] = {clock_module_enable, 1'b0, value_write_unlock,
                          ripple_warning, half_second_flag, clock_output_enable,
                          value_window_pointer, drift_calibration};
    else if (sel.val)
      rdata_next[15:0] = {value_window_high, value_window_low};
    else if (sel.alcfg)
      rdata_next[15:0] = {alarm_ctl_reg, alarm_window_pointer, alarm_config_repeat};
    else if (sel.alval)
      rdata_next[15:0] = {alarm_window_high, alarm_window_low};
    else if (sel.pad)
      rdata_next[15:0] = {14'h0, pad_reg};
  end

  // ==========================================================
  // configuration register, power-on reset only
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      clock_module_enable <= 1'b0;
      value_write_unlock  <= 1'b0;
      clock_output_enable <= 1'b0;
      drift_calibration   <= `RWC_RST_CAL;
    end
    else if (pclk_en && wr_done && sel.cfg)
    begin
      if (pstrb[1])
      begin
        if (value_write_unlock)
          clock_module_enable <= pwdata[`RWC_CFG_EN];
        value_write_unlock  <= pwdata[`RWC_CFG_WREN];
        clock_output_enable <= pwdata[`RWC_CFG_OE];
      end
      if (pstrb[0])
        drift_calibration <= pwdata[`RWC_CAL_HI:`RWC_CAL_LO];
    end
  end

  // value pointer
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      value_window_pointer <= `RWC_RST_PTR;
    else if (pclk_en)
    begin
      if (wr_done && sel.cfg && pstrb[1])
        value_window_pointer <= pwdata[`RWC_PTR_HI:`RWC_PTR_LO];
      else if (done && sel.val && (!pwrite || pstrb[1]) && value_window_pointer != 2'h0)
        value_window_pointer <= value_window_pointer - 2'h1;
    end
  end

  // half second and ripple status
  assign rollover = half_tick & clock_module_enable & half_second_flag;

  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      half_second_flag <= 1'b0;
      ripple_warning   <= 1'b0;
    end
    else if (pclk_en)
    begin
      // a tick in the clearing cycle still counts from the cleared value
      if (wr_done && sel.val && pstrb[0] && value_write_unlock
          && value_window_pointer == 2'h0)
        half_second_flag <= half_tick & clock_module_enable;
      else if (half_tick && clock_module_enable)
        half_second_flag <= ~half_second_flag;
      // rollover lands at the end of the second half
      ripple_warning <= clock_module_enable & (half_second_flag ^ half_tick);
    end
  end

  // ==========================================================
  // tick input
  rwc_tick_sync
  #(
    .STAGES     (`RWC_SYNC_STAGES)
  )
  u_tick
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pclk_en    (pclk_en),
    .tick_pin   (half_tick_pin),
    .tick_pulse (half_tick)
  );

  // ==========================================================
  // value storage and seconds/minutes counting
  assign sec_inc = (val_mem[0] == `RWC_BCD_MAX) ? {1'b1, 8'h00} :
                   (val_mem[0][3:0] == 4'h9) ? {1'b0, val_mem[0][7:4] + 4'h1, 4'h0} :
                   {1'b0, val_mem[0] + 8'h01};
  assign min_inc = (val_mem[1] == `RWC_BCD_MAX) ? {1'b1, 8'h00} :
                   (val_mem[1][3:0] == 4'h9) ? {1'b0, val_mem[1][7:4] + 4'h1, 4'h0} :
                   {1'b0, val_mem[1] + 8'h01};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        val_mem[i] <= `RWC_RST_BYTE;
    end
    else if (pclk_en)
    begin
      if (rollover)
      begin
        val_mem[0] <= sec_inc[7:0];
        if (sec_inc[8])
          val_mem[1] <= min_inc[7:0];
      end
      // software write wins over the count on the same byte
      if (wr_done && sel.val && value_write_unlock)
      begin
        if (pstrb[1] && val_idx_hi != `RWC_IDX_NONE_VAL)
          val_mem[val_idx_hi] <= pwdata[15:8];
        if (pstrb[0])
          val_mem[val_idx_lo] <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // alarm configuration and storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_ctl_reg        <= `RWC_RST_ALCTL;
      alarm_config_repeat  <= `RWC_RST_BYTE;
      alarm_window_pointer <= `RWC_RST_PTR;
    end
    else if (pclk_en)
    begin
      if (wr_done && sel.alcfg && pstrb[1])
      begin
        alarm_ctl_reg        <= pwdata[15:`RWC_ALC_CTL_LO];
        alarm_window_pointer <= pwdata[`RWC_PTR_HI:`RWC_PTR_LO];
      end
      else if (done && sel.alval && (!pwrite || pstrb[1]) && alarm_window_pointer != 2'h0)
        alarm_window_pointer <= alarm_window_pointer - 2'h1;
      if (wr_done && sel.alcfg && pstrb[0])
        alarm_config_repeat <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        al_mem[i] <= `RWC_RST_BYTE;
    end
    else if (pclk_en && wr_done && sel.alval)
    begin
      if (pstrb[1] && al_idx_hi != `RWC_IDX_NONE_VAL)
        al_mem[al_idx_hi] <= pwdata[15:8];
      if (pstrb[0] && al_idx_lo != `RWC_IDX_NONE_AL)
        al_mem[al_idx_lo] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // pad configuration and clock output pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pad_reg <= `RWC_RST_PAD;
    else if (pclk_en && wr_done && sel.pad && pstrb[0])
      pad_reg <= pwdata[`RWC_PAD_SEL:`RWC_PAD_BUF];
  end

  // alarm pulse: matches minutes and seconds only, deeper fields not compared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_hit_reg  <= 1'b0;
      clock_out      <= 1'b0;
      clock_out_oe   <= 1'b0;
      module_running <= 1'b0;
    end
    else if (pclk_en)
    begin
      alarm_hit_reg  <= clock_module_enable & alarm_ctl_reg[5]
                        & (val_mem[0] == al_mem[0]) & (val_mem[1] == al_mem[1]);
      clock_out      <= clock_output_enable & (pad_reg[1] ? ~half_second_flag
                                                          : alarm_hit_reg);
      clock_out_oe   <= clock_output_enable;
      module_running <= clock_module_enable;
    end
  end

endmodule // rwc_window_ctrl

// File: verif/rwc_window_ctrl_sva.sv
// Purpose: port checks of the register window block
// Assumes: one clock; presetn low disables every check
// Notes:   bound from the bench top file
`timescale 1ns/1ps

module rwc_window_ctrl_sva
  import rwc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              por_n,
  input wire logic              pclk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              half_tick_pin,
  input wire logic              clock_out,
  input wire logic              clock_out_oe,
  input wire logic              module_running
);
  // ==========================================================
  // helpers
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  // access phase not yet answered
  assign acc    = psel && penable && pclk_en && !pready;
  assign mapped = (paddr >> 5) == 0 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h4;

  // ==========================================================
  // bus answer
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_due: assert property (acc |=> pready)
    else $error("no pready after access phase");
  chk_ready_src: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("pready without access phase");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside pready cycle");
  chk_upper_zero: assert property (prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("error without pready");
  chk_unmapped_err: assert property (acc && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && mapped |=> !pslverr)
    else $error("mapped access refused");

  // ==========================================================
  // run and output enable pins follow the configuration only after writes or resets; clock output only while enabled
  chk_out_gated: assert property (clock_out |-> clock_out_oe)
    else $error("clock output without enable");
  chk_run_cause: assert property ($changed(module_running) |-> $past(pready)
    || $past(pready, 2) || !por_n || !$past(por_n) || !$past(presetn)
    || !$past(presetn, 2))
    else $error("run pin changed without write");
  chk_oe_cause: assert property ($changed(clock_out_oe) |-> $past(pready)
    || $past(pready, 2) || !por_n || !$past(por_n) || !$past(presetn)
    || !$past(presetn, 2))
    else $error("output enable changed without write");
endmodule // rwc_window_ctrl_sva

// File: verif/rwc_window_ctrl_tb.sv
// Purpose: self-checking bench of the register window block
// Assumes: one APB transfer at a time, random pclk_en stalls of 0 to 2 cycles in setup with psel high
// Notes:   scoreboard model compared on every read and on the pins
`timescale 1ns/1ps

module rwc_window_ctrl_tb;
  import rwc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        por_n = 1'b0;
  logic        pclk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        half_tick_pin = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clock_out;
  logic        clock_out_oe;
  logic        module_running;
  logic [31:0] rdv;
  logic        errv;
  logic [11:0] a;
  bit          en, unl, oe, half;
  bit [1:0]    ptr, pad;
  bit [7:0]    cal;
  bit [15:0]   alc;
  bit [7:0]    vh [4], vl [4], ah [4], al [4];
  int          n_errors = 0, n_compared = 0, cyc = 0, seed = 70489;

  rwc_window_ctrl #(.ADDR_W(12)) rwc_window_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .half_tick_pin(half_tick_pin), .clock_out(clock_out),
    .clock_out_oe(clock_out_oe), .module_running(module_running));

  always #4 pclk = ~pclk;

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    k = $unsigned($random(seed)) % 3;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    pclk_en <= (k == 0);
    if (k != 0)
    begin
      repeat (k) @(posedge pclk);
      pclk_en <= 1'b1;
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk("slave error", errv, !(ad inside {12'h0, 12'h4, 12'h8, 12'hC, 12'h10}));
  endtask

  task automatic wr(input logic [11:0] ad, input logic [15:0] d, input logic [3:0] s);
    bit [1:0] q;
    q = alc[9:8];
    bus(1'b1, ad, {16'h0, d}, s);
    case (ad)
      12'h000:
      begin
        if (s[1] && unl) en = d[15];
        if (s[1]) {unl, oe, ptr} = {d[13], d[10], d[9:8]};
        if (s[0]) cal = d[7:0];
      end
      12'h004:
      begin
        if (s[1] && unl && ptr != 2'h3) vh[ptr] = d[15:8];
        if (s[0] && unl) vl[ptr] = d[7:0];
        if (s[0] && unl && ptr == 2'h0) half = 1'b0;
        if (s[1] && ptr != 2'h0) ptr = ptr - 2'h1;
      end
      12'h008: alc = (alc & ~{{8{s[1]}}, {8{s[0]}}}) | (d & {{8{s[1]}}, {8{s[0]}}});
      12'h00C:
      begin
        if (s[1] && q != 2'h3) ah[q] = d[15:8];
        if (s[0] && q != 2'h3) al[q] = d[7:0];
        if (s[1] && q != 2'h0) alc[9:8] = q - 2'h1;
      end
      12'h010: if (s[0]) pad = d[1:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [11:0] ad);
    bit [15:0] e;
    bit [1:0]  q;
    q = alc[9:8];
    case (ad)
      12'h000: e = {en, 1'b0, unl, en & half, half, oe, ptr, cal};
      12'h004: e = {ptr == 2'h3 ? 8'h0 : vh[ptr], vl[ptr]};
      12'h008: e = alc;
      12'h00C: e = q == 2'h3 ? 16'h0 : {ah[q], al[q]};
      12'h010: e = {14'h0, pad};
      default: e = 16'h0;
    endcase
    bus(1'b0, ad, $random(seed), 4'hF);
    chk("read data", rdv, {16'h0, e});
    if (ad == 12'h004 && ptr != 2'h0) ptr = ptr - 2'h1;
    if (ad == 12'h00C && q != 2'h0) alc[9:8] = q - 2'h1;
  endtask

  task automatic pins();
    bit hit;
    repeat (4) @(posedge pclk);
    hit = en && alc[15] && vh[0] == ah[0] && vl[0] == al[0];
    chk("clock out", clock_out, oe && (pad[1] ? !half : hit));
    chk("output enable", clock_out_oe, oe);
    chk("running", module_running, en);
  endtask

  // ==========================================================
  // time source and resets
  function automatic bit [15:0] bcd_step(input bit [15:0] ms);
    ms[7:0] = (ms[3:0] == 4'h9) ? {ms[7:4] + 4'h1, 4'h0} : ms[7:0] + 8'h1;
    if (ms[7:0] == 8'h60)
      ms = {(ms[11:8] == 4'h9) ? {ms[15:12] + 4'h1, 4'h0} : ms[15:8] + 8'h1, 8'h0};
    return (ms[15:8] == 8'h60) ? 16'h0 : ms;
  endfunction

  task automatic tick();
    half_tick_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    half_tick_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    if (en && half) {vh[0], vl[0]} = bcd_step({vh[0], vl[0]});
    if (en) half = !half;
  endtask

  task automatic do_reset(input bit por);
    presetn <= 1'b0;
    por_n <= !por;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    foreach (vh[i]) {vh[i], vl[i], ah[i], al[i]} = 32'h0;
    {alc, pad} = 18'h0;
    if (por) {en, unl, oe, half, ptr, cal} = 14'h0;
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================================
  // scenarios
  initial
  begin
    do_reset(1'b1);
    for (int i = 0; i <= 16; i += 4) rd(i[11:0]);
    wr(12'h000, 16'h0300, 4'h2);
    wr(12'h004, 16'($random(seed)), 4'h3);
    wr(12'h004, 16'($random(seed)), 4'h1);
    rd(12'h004);
    rd(12'h000);
    wr(12'h000, 16'hE7FF, 4'h3);
    rd(12'h000);
    pins();
    wr(12'h000, 16'hA700, 4'h2);
    pins();
    for (int w = 0; w < 2; w++)
    begin
      a = w ? 12'h00C : 12'h004;
      if (w) wr(12'h008, 16'($random(seed)) | 16'h0300, 4'h3);
      repeat (5) wr(a, 16'($random(seed)), 4'h3);
      wr(a, 16'($random(seed)), 4'h1);
      wr(w ? 12'h008 : 12'h000, w ? alc | 16'h0300 : 16'hA700, 4'h2);
      repeat (5) rd(a);
      rd(w ? 12'h008 : 12'h000);
    end
    wr(12'h010, 16'hFFFF, 4'h3);
    wr(12'h014, 16'hFFFF, 4'h3);
    rd(12'h010);
    rd(12'h014);
    rd(12'hFFC);
    rd(12'h002);
    wr(12'h000, 16'hA400, 4'h2);
    wr(12'h004, 16'h1258, 4'h3);
    wr(12'h010, 16'h0002, 4'h1);
    repeat (5)
    begin
      tick();
      rd(12'h000);
      rd(12'h000);
      rd(12'h004);
      pins();
    end
    wr(12'h004, 16'h0030, 4'h1);
    rd(12'h000);
    wr(12'h008, 16'h8000, 4'h3);
    wr(12'h00C, {vh[0], vl[0]}, 4'h3);
    wr(12'h010, 16'h0000, 4'h1);
    pins();
    wr(12'h000, 16'hA000, 4'h2);
    pins();
    do_reset(1'b0);
    rd(12'h000);
    rd(12'h004);
    pins();
    do_reset(1'b1);
    rd(12'h000);
    pins();
    final_report();
  end
endmodule // rwc_window_ctrl_tb

bind rwc_window_ctrl rwc_window_ctrl_sva #(.ADDR_W(ADDR_W)) rwc_window_ctrl_sva_inst (
  .pclk(pclk), .presetn(presetn), .por_n(por_n), .pclk_en(pclk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .half_tick_pin(half_tick_pin),
  .clock_out(clock_out), .clock_out_oe(clock_out_oe), .module_running(module_running));
